// file: core/fec_map.vh
// fec_map.vh: register map, command codes and flash command words
// assumes inclusion by the erase-control host files only
`ifndef FEC_MAP_VH
`define FEC_MAP_VH
// wishbone register byte offsets
`define FEC_REG_CTRL 4'h0
`define FEC_REG_ADDR 4'h4
`define FEC_REG_DATA 4'h8
`define FEC_REG_STAT 4'hc
// ctrl register fields
`define FEC_CTRL_CMD_LSB 0
`define FEC_CTRL_CLR_BIT 4
`define FEC_CTRL_RST_BIT 5
// status register fields
`define FEC_ST_BUSY 0
`define FEC_ST_ERASING 1
`define FEC_ST_SUSP 2
`define FEC_ST_WIN 3
`define FEC_ST_REJ 4
`define FEC_ST_CORRUPT 5
`define FEC_ST_RDY 6
`define FEC_ST_POLL 7
`define FEC_ST_TOG 8
`define FEC_ST_TOG2 9
`define FEC_ST_TWIN 10
`define FEC_ST_NSEC_LSB 16
// software commands
`define FEC_CMD_NONE 3'h0
`define FEC_CMD_CHIP 3'h1
`define FEC_CMD_SECT 3'h2
`define FEC_CMD_ADD 3'h3
`define FEC_CMD_SUSP 3'h4
`define FEC_CMD_RES 3'h5
`define FEC_CMD_POLL 3'h6
`define FEC_CMD_PROG 3'h7
// flash command words, only the low byte is decoded by the device
`define FEC_UNLOCK1_A 22'h00_0555
`define FEC_UNLOCK2_A 22'h00_02aa
`define FEC_UNLOCK1_D 16'h00aa
`define FEC_UNLOCK2_D 16'h0055
`define FEC_SETUP_D 16'h0080
`define FEC_CHIP_D 16'h0010
`define FEC_SECT_D 16'h0030
`define FEC_SUSP_D 16'h00b0
`define FEC_PROG_D 16'h00a0
// limits and timing
`define FEC_MAX_SECT 6'h26
`define FEC_WINDOW_US 50
`define FEC_CLK_MHZ 10
`define FEC_RST_CYC 8'h05
`endif

// file: core/fec_flash_cycle.v
// fec_flash_cycle: one write or read bus cycle on the flash pins
// assumes a 10 MHz sys_clk and an asynchronous flash data bus
`timescale 1ns/1ns
module fec_flash_cycle #(
   parameter AW = 22,
   parameter DW = 16
) (
   input wire sys_clk,
   input wire rst,
   input wire start,
   input wire is_read,
   input wire [AW-1:0] addr,
   input wire [DW-1:0] wdata,
   input wire [DW-1:0] dq_in,
   output reg [AW-1:0] flash_addr_r,
   output reg [DW-1:0] dq_out_r,
   output reg dq_oe_r,
   output reg ce_n_r,
   output reg we_n_r,
   output reg oe_n_r,
   output reg done_r,
   output reg [DW-1:0] rdata_r
);
   reg [2:0] ph_r;
   reg rd_r;
   reg [DW-1:0] dq_s1_r;
   reg [DW-1:0] dq_s2_r;

   // pins are asynchronous to sys_clk
   always @(posedge sys_clk) begin
      dq_s1_r <= dq_in;
      dq_s2_r <= dq_s1_r;
   end

   always @(posedge sys_clk) begin
      if (rst) begin
         ph_r <= 3'h0;
         rd_r <= 1'b0;
         flash_addr_r <= {AW{1'b0}};
         dq_out_r <= {DW{1'b0}};
         dq_oe_r <= 1'b0;
         ce_n_r <= 1'b1;
         we_n_r <= 1'b1;
         oe_n_r <= 1'b1;
         done_r <= 1'b0;
         rdata_r <= {DW{1'b0}};
      end else begin
         done_r <= 1'b0;
         case (ph_r)
            3'h0: begin
               if (start) begin
                  flash_addr_r <= addr;
                  rd_r <= is_read;
                  dq_out_r <= wdata;
                  dq_oe_r <= ~is_read;
                  ce_n_r <= ~is_read;
                  oe_n_r <= ~is_read;
                  ph_r <= 3'h1;
               end
            end
            3'h1: begin
               // address settles a cycle before the write strobe falls
               if (!rd_r) begin
                  ce_n_r <= 1'b0;
                  we_n_r <= 1'b0;
               end
               ph_r <= 3'h2;
            end
            3'h2: begin
               // rising strobe edge is where the device latches the command
               we_n_r <= 1'b1;
               ce_n_r <= rd_r ? 1'b0 : 1'b1;
               ph_r <= 3'h3;
            end
            3'h3: begin
               dq_oe_r <= 1'b0;
               ph_r <= 3'h4;
            end
            3'h4: begin
               // two sync stages plus access time are covered by now
               if (rd_r) begin
                  rdata_r <= dq_s2_r;
               end
               ce_n_r <= 1'b1;
               oe_n_r <= 1'b1;
               done_r <= 1'b1;
               ph_r <= 3'h0;
            end
            default: ph_r <= 3'h0;
         endcase
      end
   end
endmodule

// file: core/fec_ctrl.v
// fec_ctrl: host-side erase controller for a dual-bank parallel nor flash
// assumes a wishbone classic master and the flash pins wired directly
// Behaviour
// - chip erase is sent as six writes: unlock, unlock, setup, unlock x2, 10h
// - sector erase is six writes ending with 30h at a sector address
// - extra sectors are written as 30h within the window; timer restarts
// - reset during erase corrupts sectors; host flags reissue needed
// - polling reads use an address inside an erasing sector
// - resume is 30h at the suspended bank; repeats rejected and flagged
// - suspend-program allowed outside suspended sectors, polled as usual
// - commands use only the low data byte; upper lines driven zero
`timescale 1ns/1ns
`include "fec_map.vh"
module fec_ctrl #(
   parameter AW = 22,
   parameter DW = 16,
   parameter WIN_CYC = `FEC_WINDOW_US * `FEC_CLK_MHZ
) (
   input wire sys_clk,
   input wire rst,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [3:0] wb_adr_i,
   input wire [31:0] wb_dat_i,
   input wire [3:0] wb_sel_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   output wire [AW-1:0] flash_addr,
   input wire [DW-1:0] flash_dq_in,
   output wire [DW-1:0] flash_dq_out,
   output wire flash_dq_oe,
   output wire flash_ce_n,
   output wire flash_we_n,
   output wire flash_oe_n,
   output reg flash_rst_n,
   input wire ready_busy_in
);
   localparam ST_IDLE = 2'h0;
   localparam ST_ISSUE = 2'h1;
   localparam ST_WAIT = 2'h2;
   localparam SEQ_LEN = 3'h6;

   reg [1:0] st_r;
   reg [2:0] cmd_r;
   reg [2:0] step_r;
   reg [AW-1:0] addr_r;
   reg [DW-1:0] data_r;
   reg [DW-1:0] rd1_r;
   reg erasing_r;
   reg sect_mode_r;
   reg susp_r;
   reg rej_r;
   reg corrupt_r;
   reg [5:0] nsec_r;
   reg [15:0] win_r;
   reg [7:0] rcnt_r;
   reg rb_s1_r;
   reg rb_s2_r;
   reg cyc_start_r;
   reg cyc_read_r;
   reg [AW-1:0] cyc_addr_r;
   reg [DW-1:0] cyc_wdata_r;
   wire cyc_done;
   wire [DW-1:0] cyc_rdata;
   wire wb_req;
   wire [2:0] wr_cmd;
   wire cmd_go;
   reg cmd_ok;
   reg [AW+DW-1:0] step_word;
   reg [2:0] step_cnt;
   reg [31:0] stat;

   fec_flash_cycle #(.AW(AW), .DW(DW)) u_cycle (
      .sys_clk(sys_clk),
      .rst(rst),
      .start(cyc_start_r),
      .is_read(cyc_read_r),
      .addr(cyc_addr_r),
      .wdata(cyc_wdata_r),
      .dq_in(flash_dq_in),
      .flash_addr_r(flash_addr),
      .dq_out_r(flash_dq_out),
      .dq_oe_r(flash_dq_oe),
      .ce_n_r(flash_ce_n),
      .we_n_r(flash_we_n),
      .oe_n_r(flash_oe_n),
      .done_r(cyc_done),
      .rdata_r(cyc_rdata)
   );

   // ready/busy is an open-drain pin from another domain
   always @(posedge sys_clk) begin
      rb_s1_r <= ready_busy_in;
      rb_s2_r <= rb_s1_r;
   end

   // address/data of each write step, low byte only for commands
   always @* begin
      step_word = {`FEC_UNLOCK1_A, `FEC_UNLOCK1_D};
      step_cnt = 3'h1;
      case (cmd_r)
         `FEC_CMD_CHIP, `FEC_CMD_SECT: begin
            step_cnt = SEQ_LEN;
            case (step_r)
               3'h0: step_word = {`FEC_UNLOCK1_A, `FEC_UNLOCK1_D};
               3'h1: step_word = {`FEC_UNLOCK2_A, `FEC_UNLOCK2_D};
               3'h2: step_word = {`FEC_UNLOCK1_A, `FEC_SETUP_D};
               3'h3: step_word = {`FEC_UNLOCK1_A, `FEC_UNLOCK1_D};
               3'h4: step_word = {`FEC_UNLOCK2_A, `FEC_UNLOCK2_D};
               default: begin
                  if (cmd_r == `FEC_CMD_CHIP) begin
                     step_word = {`FEC_UNLOCK1_A, `FEC_CHIP_D};
                  end else begin
                     step_word = {addr_r, `FEC_SECT_D};
                  end
               end
            endcase
         end
         `FEC_CMD_PROG: begin
            step_cnt = 3'h4;
            case (step_r)
               3'h0: step_word = {`FEC_UNLOCK1_A, `FEC_UNLOCK1_D};
               3'h1: step_word = {`FEC_UNLOCK2_A, `FEC_UNLOCK2_D};
               3'h2: step_word = {`FEC_UNLOCK1_A, `FEC_PROG_D};
               default: step_word = {addr_r, data_r};
            endcase
         end
         `FEC_CMD_ADD, `FEC_CMD_RES: step_word = {addr_r, `FEC_SECT_D};
         `FEC_CMD_SUSP: step_word = {addr_r, `FEC_SUSP_D};
         `FEC_CMD_POLL: begin
            step_cnt = 3'h2;
            step_word = {addr_r, {DW{1'b0}}};
         end
         default: step_word = {`FEC_UNLOCK1_A, `FEC_UNLOCK1_D};
      endcase
   end

   assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_cmd = wb_dat_i[`FEC_CTRL_CMD_LSB +: 3];
   assign cmd_go = wb_req & wb_we_i & wb_sel_i[0]
      & (wb_adr_i == `FEC_REG_CTRL) & (wr_cmd != `FEC_CMD_NONE);

   // which orders the current erase state allows
   always @* begin
      cmd_ok = 1'b0;
      case (wr_cmd)
         `FEC_CMD_CHIP, `FEC_CMD_SECT: cmd_ok = ~erasing_r;
         `FEC_CMD_ADD: cmd_ok = sect_mode_r & (win_r != 16'h0000)
            & (nsec_r < `FEC_MAX_SECT);
         `FEC_CMD_SUSP: cmd_ok = sect_mode_r & ~susp_r;
         `FEC_CMD_RES: cmd_ok = susp_r;
         `FEC_CMD_POLL: cmd_ok = 1'b1;
         // program only while idle or suspended
         `FEC_CMD_PROG: cmd_ok = ~erasing_r | susp_r;
         default: cmd_ok = 1'b0;
      endcase
      if (st_r != ST_IDLE) begin
         cmd_ok = 1'b0;
      end
   end

   always @* begin
      stat = 32'h0000_0000;
      stat[`FEC_ST_BUSY] = (st_r != ST_IDLE);
      stat[`FEC_ST_ERASING] = erasing_r;
      stat[`FEC_ST_SUSP] = susp_r;
      stat[`FEC_ST_WIN] = (win_r != 16'h0000);
      stat[`FEC_ST_REJ] = rej_r;
      stat[`FEC_ST_CORRUPT] = corrupt_r;
      stat[`FEC_ST_RDY] = rb_s2_r;
      stat[`FEC_ST_POLL] = cyc_rdata[7];
      stat[`FEC_ST_TOG] = rd1_r[6] ^ cyc_rdata[6];
      stat[`FEC_ST_TOG2] = rd1_r[2] ^ cyc_rdata[2];
      stat[`FEC_ST_TWIN] = cyc_rdata[3];
      stat[`FEC_ST_NSEC_LSB +: 6] = nsec_r;
   end

   // wishbone slave: ack one cycle after the request, zero for holes
   always @(posedge sys_clk) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_req;
         if (wb_req) begin
            case (wb_adr_i)
               `FEC_REG_CTRL: wb_dat_o <= {29'h0000_0000, cmd_r};
               `FEC_REG_ADDR: wb_dat_o <= {{(32-AW){1'b0}}, addr_r};
               `FEC_REG_DATA: wb_dat_o <= {{(32-DW){1'b0}}, cyc_rdata};
               `FEC_REG_STAT: wb_dat_o <= stat;
               default: wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   // sequencer plus erase bookkeeping
   always @(posedge sys_clk) begin
      if (rst) begin
         st_r <= ST_IDLE;
         cmd_r <= `FEC_CMD_NONE;
         step_r <= 3'h0;
         addr_r <= {AW{1'b0}};
         data_r <= {DW{1'b0}};
         rd1_r <= {DW{1'b0}};
         erasing_r <= 1'b0;
         sect_mode_r <= 1'b0;
         susp_r <= 1'b0;
         rej_r <= 1'b0;
         corrupt_r <= 1'b0;
         nsec_r <= 6'h00;
         win_r <= 16'h0000;
         rcnt_r <= 8'h00;
         flash_rst_n <= 1'b1;
         cyc_start_r <= 1'b0;
         cyc_read_r <= 1'b0;
         cyc_addr_r <= {AW{1'b0}};
         cyc_wdata_r <= {DW{1'b0}};
      end else begin
         cyc_start_r <= 1'b0;
         if (win_r != 16'h0000) begin
            win_r <= win_r - 16'h0001;
         end
         if (wb_req & wb_we_i & (wb_adr_i == `FEC_REG_ADDR)) begin
            addr_r <= wb_dat_i[AW-1:0];
         end
         if (wb_req & wb_we_i & (wb_adr_i == `FEC_REG_DATA)) begin
            data_r <= wb_dat_i[DW-1:0];
         end
         if (wb_req & wb_we_i & (wb_adr_i == `FEC_REG_CTRL)) begin
            if (wb_dat_i[`FEC_CTRL_CLR_BIT]) begin
               rej_r <= 1'b0;
               corrupt_r <= 1'b0;
            end
            // a reset pulse mid-erase leaves sectors needing reissue
            if (wb_dat_i[`FEC_CTRL_RST_BIT] & (rcnt_r == 8'h00)) begin
               rcnt_r <= `FEC_RST_CYC;
               flash_rst_n <= 1'b0;
               if (erasing_r) begin
                  corrupt_r <= 1'b1;
               end
               erasing_r <= 1'b0;
               sect_mode_r <= 1'b0;
               susp_r <= 1'b0;
               win_r <= 16'h0000;
            end
         end
         if (rcnt_r != 8'h00) begin
            rcnt_r <= rcnt_r - 8'h01;
            flash_rst_n <= (rcnt_r == 8'h01);
         end
         // a set wins over a clear written in the same cycle
         if (cmd_go & (~cmd_ok | (rcnt_r != 8'h00))) begin
            rej_r <= 1'b1;
         end
         case (st_r)
            ST_IDLE: begin
               if (cmd_go & cmd_ok & (rcnt_r == 8'h00)) begin
                  cmd_r <= wr_cmd;
                  step_r <= 3'h0;
                  st_r <= ST_ISSUE;
               end
            end
            ST_ISSUE: begin
               cyc_start_r <= 1'b1;
               cyc_read_r <= (cmd_r == `FEC_CMD_POLL);
               cyc_addr_r <= step_word[AW+DW-1:DW];
               cyc_wdata_r <= step_word[DW-1:0];
               st_r <= ST_WAIT;
            end
            ST_WAIT: begin
               if (cyc_done) begin
                  if (step_r == 3'h0) begin
                     rd1_r <= cyc_rdata;
                  end
                  if (step_r + 3'h1 < step_cnt) begin
                     step_r <= step_r + 3'h1;
                     st_r <= ST_ISSUE;
                  end else begin
                     st_r <= ST_IDLE;
                     case (cmd_r)
                        `FEC_CMD_CHIP: erasing_r <= 1'b1;
                        `FEC_CMD_SECT: begin
                           erasing_r <= 1'b1;
                           sect_mode_r <= 1'b1;
                           nsec_r <= 6'h01;
                           win_r <= WIN_CYC[15:0];
                        end
                        `FEC_CMD_ADD: begin
                           nsec_r <= nsec_r + 6'h01;
                           win_r <= WIN_CYC[15:0];
                        end
                        `FEC_CMD_SUSP: begin
                           susp_r <= 1'b1;
                           win_r <= 16'h0000;
                        end
                        `FEC_CMD_RES: susp_r <= 1'b0;
                        `FEC_CMD_POLL: begin
                           // bit 7 high and toggling stopped
                           if (erasing_r & ~susp_r & cyc_rdata[7]
                              & (rd1_r[6] == cyc_rdata[6])) begin
                              erasing_r <= 1'b0;
                              sect_mode_r <= 1'b0;
                           end
                        end
                        default: cmd_r <= cmd_r;
                     endcase
                  end
               end
            end
            default: st_r <= ST_IDLE;
         endcase
      end
   end
endmodule

// file: sim/fec_ctrl_monitor.sv
// fec_ctrl_monitor: port-level checks of the erase controller
// assumes a bind into fec_ctrl, one sys_clk domain
`timescale 1ns/1ns
module fec_ctrl_monitor #(
   parameter AW = 22,
   parameter DW = 16
) (
   input wire sys_clk,
   input wire rst,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_ack_o,
   input wire [AW-1:0] flash_addr,
   input wire [DW-1:0] flash_dq_out,
   input wire flash_dq_oe,
   input wire flash_ce_n,
   input wire flash_we_n,
   input wire flash_oe_n,
   input wire flash_rst_n
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing after request");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_spur: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
      else $error("ack without request");
   a_rst_quiet: assert property ($fell(rst) |-> !wb_ack_o && flash_ce_n
      && !flash_dq_oe && flash_rst_n) else $error("outputs busy after reset");
   a_we_framed: assert property (
      !flash_we_n |-> !flash_ce_n && flash_dq_oe && flash_oe_n)
      else $error("write strobe outside a write cycle");
   a_we_pulse: assert property ($fell(flash_we_n) |=> flash_we_n)
      else $error("write strobe too long");
   a_wr_stable: assert property (!flash_we_n |-> $stable(flash_addr)
      && $stable(flash_dq_out) ##1 $stable(flash_addr)
      && $stable(flash_dq_out)) else $error("write data moved");
   a_rd_nodrive: assert property (!flash_oe_n |->
      !flash_dq_oe && flash_we_n) else $error("bus driven during read");
   a_unlock_byte: assert property (!flash_we_n
      && flash_addr == 22'h00_0555 |-> flash_dq_out[15:8] == 8'h00)
      else $error("upper byte set");
   a_frst_len: assert property ($fell(flash_rst_n) |=>
      !flash_rst_n [*4] ##1 flash_rst_n)
      else $error("flash reset pulse length");
   c_chip: cover property (!flash_we_n && flash_dq_out == 16'h0010);
   c_susp: cover property (!flash_we_n && flash_dq_out == 16'h00b0);
   c_sect: cover property (!flash_we_n && flash_dq_out == 16'h0030);
   c_frst: cover property ($fell(flash_rst_n));
endmodule
bind fec_ctrl fec_ctrl_monitor #(.AW(AW), .DW(DW)) i_mon (
   .sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
   .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n),
   .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n),
   .flash_rst_n(flash_rst_n));

// file: sim/fec_flash_model.sv
// fec_flash_model: behavioural dual-bank nor flash, erase and suspend commands plus single-word program
// assumes strobes from fec_ctrl and a pull-up on ready_busy_out
`timescale 1ns/1ns
module fec_flash_model #(
   parameter WIN_T = 100,
   parameter ERASE_T = 300
) (
   input wire [21:0] addr,
   input wire [15:0] dq_in,
   input wire ce_n,
   input wire we_n,
   input wire oe_n,
   input wire rst_n,
   output wire [15:0] dq_out,
   output wire ready_busy_out
);
   reg [63:0] sel_r = 0, er_mask_r = 0;
   reg [21:0] a_r = 0, pa_r = 22'h3f_ffff;
   reg [15:0] pd_r = 0, last_r = 0;
   reg busy_r = 0, win_r = 0, susp_r = 0, chip_r = 0, chipx_r = 0;
   reg corrupt_r = 0, t6_r = 0, t2_r = 0;
   integer step = 0, tick = 0, left = 0;
   wire [7:0] d = dq_in[7:0];
   wire rd = !ce_n && !oe_n;
   // cross-bank erase hides both banks: status everywhere but suspend reads outside the erasing sectors
   wire stat = (busy_r || win_r) && !(susp_r && !sel_r[addr[21:16]]);
   wire [15:0] arr = (addr == pa_r) ? pd_r :
      (chip_r || er_mask_r[addr[21:16]]) ? 16'hffff : 16'h1234;
   // undriven bus shows the inverse of the last word, never a held value
   assign dq_out = !rd ? ~last_r : stat ? {8'h00, susp_r, t6_r, 2'b00,
      busy_r, t2_r, 2'b00} : arr;
   assign ready_busy_out = (busy_r && !susp_r) ? 1'b0 : 1'bz;
   always @(negedge we_n) a_r = addr;
   always @(negedge oe_n) begin
      if (!ce_n && stat) begin
         t6_r = t6_r ^ !susp_r;
         t2_r = t2_r ^ sel_r[addr[21:16]];
      end
      #1 last_r = dq_out;
   end
   always @(posedge we_n) begin
      if (win_r && d == 8'h30 && step == 0) begin
         sel_r[a_r[21:16]] = 1'b1;
         tick = 0;
      end else if ((win_r || busy_r) && !susp_r && !chipx_r && d == 8'hb0) begin
         if (win_r) left = ERASE_T;
         win_r = 0;
         busy_r = 1;
         susp_r = 1;
      end else if (susp_r && d == 8'h30 && step == 0) susp_r = 0;
      else if (!busy_r || susp_r) begin
         case (step)
            0: step = (a_r[11:0] == 12'h555 && d == 8'haa) ? 1 : 0;
            1: step = (a_r[11:0] == 12'h2aa && d == 8'h55) ? 2 : 0;
            2: step = (d == 8'h80) ? 3 : (d == 8'ha0) ? 6 : 0;
            3: step = (d == 8'haa) ? 4 : 0;
            4: step = (d == 8'h55) ? 5 : 0;
            5: begin
               step = 0;
               if (d == 8'h10 && !susp_r) begin
                  sel_r = {64{1'b1}};
                  chipx_r = 1;
                  busy_r = 1;
                  left = ERASE_T;
               end else if (d == 8'h30 && !susp_r) begin
                  sel_r = 0;
                  sel_r[a_r[21:16]] = 1'b1;
                  win_r = 1;
                  tick = 0;
               end
            end
            6: begin
               step = 0;
               pa_r = a_r;
               pd_r = dq_in;
            end
            default: step = 0;
         endcase
      end
   end
   always #100 begin
      if (win_r) begin
         tick = tick + 1;
         if (tick >= WIN_T) begin
            win_r = 0;
            busy_r = 1;
            left = ERASE_T;
         end
      end else if (busy_r && !susp_r) begin
         left = left - 1;
         if (left <= 0) begin
            er_mask_r = sel_r;
            chip_r = chip_r | chipx_r;
            busy_r = 0;
            chipx_r = 0;
            sel_r = 0;
         end
      end
   end
   always @(negedge rst_n) begin
      corrupt_r = busy_r | win_r;
      busy_r = 0;
      win_r = 0;
      susp_r = 0;
      chipx_r = 0;
      sel_r = 0;
      step = 0;
   end
endmodule

// file: sim/fec_ctrl_tb.sv
// fec_ctrl_tb: self-checking bench, wishbone master plus flash model
// assumes fec_map.vh on the include path
`timescale 1ns/1ns
`include "fec_map.vh"
module fec_ctrl_tb;
   reg sys_clk = 0, rst = 1, cyc = 0, stb = 0, we = 0;
   reg [3:0] adr = 4'h0;
   reg [31:0] dat = 32'h0, q;
   wire [31:0] rdat;
   wire ack, dq_oe, ce_n, we_n, oe_n, frst_n;
   wire [21:0] fa;
   wire [15:0] dq_o, dq_i;
   tri1 rb;
   integer n_fail = 0, n_tests = 0;
   always #50 sys_clk = ~sys_clk;
   // short window keeps the run brief; model window stays longer
   fec_ctrl #(.WIN_CYC(40)) i_dut (.sys_clk(sys_clk), .rst(rst),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_dat_i(dat), .wb_sel_i(4'hf), .wb_dat_o(rdat), .wb_ack_o(ack),
      .flash_addr(fa), .flash_dq_in(dq_i), .flash_dq_out(dq_o),
      .flash_dq_oe(dq_oe), .flash_ce_n(ce_n), .flash_we_n(we_n),
      .flash_oe_n(oe_n), .flash_rst_n(frst_n), .ready_busy_in(rb));
   fec_flash_model i_flash (.addr(fa), .dq_in(dq_o), .ce_n(ce_n),
      .we_n(we_n), .oe_n(oe_n), .rst_n(frst_n), .dq_out(dq_i),
      .ready_busy_out(rb));
   task chk(input string nm, input [63:0] e, input [63:0] g);
      begin
         n_tests = n_tests + 1;
         if (e !== g) begin
            n_fail = n_fail + 1;
            $display("BAD %s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task wb(input w, input [3:0] a, input [31:0] d);
      integer k;
      begin
         k = 0;
         @(posedge sys_clk);
         cyc <= 1;
         stb <= 1;
         we <= w;
         adr <= a;
         dat <= d;
         @(posedge sys_clk);
         while (ack !== 1'b1 && k < 50) begin
            @(posedge sys_clk);
            k = k + 1;
         end
         if (k == 50) n_fail = n_fail + 1;
         q = rdat;
         cyc <= 0;
         stb <= 0;
         we <= 0;
      end
   endtask
   task cmd(input [21:0] a, input [31:0] c);
      integer k;
      begin
         k = 0;
         wb(1, `FEC_REG_ADDR, {10'h0, a});
         wb(1, `FEC_REG_CTRL, c);
         q = 1;
         while (q[0] !== 1'b0 && k < 400) begin
            wb(0, `FEC_REG_STAT, 0);
            k = k + 1;
         end
         if (k == 400) n_fail = n_fail + 1;
      end
   endtask
   task poll_end(input [21:0] a);
      integer k;
      begin
         k = 0;
         q = 2;
         while (q[1] !== 1'b0 && k < 200) begin
            cmd(a, `FEC_CMD_POLL);
            k = k + 1;
         end
      end
   endtask
   task t_reset;
      begin
         wb(0, `FEC_REG_STAT, 0);
         chk("stat", 32'h0000_0040, q);
         wb(0, 4'h1, 0);
         chk("unmapped", 32'h0000_0000, q);
      end
   endtask
   task t_chip;
      begin
         cmd(22'h0, `FEC_CMD_CHIP);
         chk("chip busy", 32'h0000_0002, q & 32'h0000_0042);
         poll_end(22'h0);
         chk("chip done", 32'h0000_0080, q & 32'h0000_0082);
         chk("chip erased", 1, i_flash.chip_r);
      end
   endtask
   task t_sect;
      begin
         cmd(22'h05_0000, `FEC_CMD_SECT);
         cmd(22'h32_0000, `FEC_CMD_ADD);
         chk("queued", 32'h0002_0008, q & 32'h003f_0008);
         cmd(22'h32_0000, `FEC_CMD_POLL);
         chk("window open", 0, q[10]);
         repeat (150) @(posedge sys_clk);
         cmd(22'h20_0000, `FEC_CMD_ADD);
         chk("late add", 32'h0000_0010, q & 32'h0000_0010);
         cmd(22'h32_0000, `FEC_CMD_POLL);
         chk("window shut", 1, q[10]);
         poll_end(22'h05_0000);
         chk("mask", 64'h0004_0000_0000_0020, i_flash.er_mask_r);
      end
   endtask
   task t_susp;
      begin
         cmd(22'h0, 32'h0000_0010);
         cmd(22'h08_0000, `FEC_CMD_SECT);
         cmd(22'h08_0000, `FEC_CMD_SUSP);
         cmd(22'h08_0000, `FEC_CMD_POLL);
         chk("suspended", 32'h0000_02c4, q & 32'h0000_03d4);
         cmd(22'h08_0000, `FEC_CMD_SUSP);
         chk("susp again", 32'h0000_0014, q & 32'h0000_0014);
         cmd(22'h06_0000, `FEC_CMD_POLL);
         wb(0, `FEC_REG_DATA, 0);
         chk("susp read", 32'h0000_ffff, q);
         wb(1, `FEC_REG_DATA, 32'h0000_5a3c);
         cmd(22'h10_0004, `FEC_CMD_PROG);
         chk("prog addr", 22'h10_0004, i_flash.pa_r);
         chk("prog data", 16'h5a3c, i_flash.pd_r);
         cmd(22'h08_0000, `FEC_CMD_RES);
         chk("resumed", 0, q[2]);
         cmd(22'h0, 32'h0000_0010);
         cmd(22'h08_0000, `FEC_CMD_RES);
         chk("resume again", 32'h0000_0010, q & 32'h0000_0014);
         poll_end(22'h08_0000);
         chk("susp mask", 64'h0000_0000_0000_0100, i_flash.er_mask_r);
      end
   endtask
   task t_rst;
      begin
         cmd(22'h0, `FEC_CMD_CHIP);
         cmd(22'h0, 32'h0000_0020);
         chk("corrupt", 32'h0000_0020, q & 32'h0000_0020);
         chk("dev corrupt", 1, i_flash.corrupt_r);
         cmd(22'h0, 32'h0000_0010);
         chk("cleared", 0, q[5]);
      end
   endtask
   task close_out;
      begin
         $display("tests %0d failures %0d", n_tests, n_fail);
         if (n_fail == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   initial begin
      repeat (12) @(posedge sys_clk);
      rst <= 0;
      repeat (3) @(posedge sys_clk);
      t_reset;
      t_chip;
      t_sect;
      t_susp;
      t_rst;
      close_out;
   end
   // whole run is a few thousand cycles; 40000 means a hang
   initial begin
      #4_000_000;
      n_fail = n_fail + 1;
      close_out;
   end
endmodule
